// ===== hdl/eeprom_pkg.sv
/*
 Shared constants for the three-wire serial word EEPROM link: widths,
 opcode layout, timing figures and the host command kinds.
 Assumes a 100 MHz ref_clk on both ends.
*/
package eeprom_pkg;
    localparam int CLK_MHZ = 100;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int OP_W = 2;
    localparam int WORDS_W = 8;
    // Opcode after the start bit
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    // Top two address bits select the extended command
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
    // Leading dummy clocks for a 16-bit frame
    localparam int LEAD_PAD_SMALL = 7;
    localparam int LEAD_PAD_LARGE = 5;
    // Program cycle, typical and maximum, in microseconds
    localparam int PROG_TYP_US = 4000;
    localparam int PROG_MAX_US = 8000;
    localparam int PROG_CYC = PROG_TYP_US * CLK_MHZ;
    // Deselect gap and serial clock half period, in nanoseconds
    localparam int GAP_NS = 200;
    localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int SK_HALF_NS = 500;
    localparam int SK_HALF_CYC = (SK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int POLL_SETTLE_CYC = 8;
    typedef enum logic [2:0] {
        CMD_READ, CMD_WRITE, CMD_ERASE, CMD_WRITE_ALL, CMD_ERASE_ALL, CMD_ENABLE, CMD_DISABLE
    } cmd_type;
endpackage

// ===== hdl/eeprom_link_if.sv
/*
 Pins between the host and the EEPROM device.
 Assumes the data-out wire has a pull-up, so an undriven line reads high.
*/
`timescale 1ns/1ps
interface eeprom_link_if;
    logic cs;
    logic sclk;
    logic sdi;
    logic sdo_out;
    logic sdo_oe;
    logic sdo_line;

    assign sdo_line = sdo_oe ? sdo_out : 1'b1;

    modport device (input cs, input sclk, input sdi, output sdo_out, output sdo_oe);
    modport host (output cs, output sclk, output sdi, input sdo_line);
endinterface

// ===== hdl/link_sync.sv
/*
 Two-flop synchroniser for link pins.
 Assumes inputs are asynchronous to ref_clk; only the second stage is read.
*/
`timescale 1ns/1ps
module link_sync #(
    parameter int W = 1
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    // Pins
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_type;

    sync_state_type q;
    sync_state_type d;

    always_comb begin
        d = q;
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign sync_out = q.s2;
endmodule

// ===== hdl/eeprom_device.sv
/*
 Device end of the three-wire serial word EEPROM: command receiver,
 sequential read, program cycle timer, status reporting and the array.
 Assumes link pins come from another clock domain; ref_clk samples the
 serial clock and finds its edges, so it must run well above it.
*/
// Summary of operation
// - Shift in start, opcode, address, data on rising clock
// - Select falling ends command input; gap between commands
// - Deselected device ignores clock and data
// - First rising edge with input high is start
// - Leading low clocks before start are ignored
// - Drive low dummy bit after last address bit
// - Then shift addressed word out, one bit per edge
// - Keep clocking reads following words
// - Read address wraps from top to zero
// - Program cycle starts when select falls
// - Clock and data ignored while programming
// - Host starts only while output high or floating
// - Programming needs program-enable mode
// - Program cycle ends within maximum time
// - Status shown while reselected after programming
// - Output low busy, high ready
// - Host may hold or re-enter to poll
// - Host holds input low while polling
// - Start bit while ready floats output at once
// - Array starts all ones
// - Enable and disable commands set mode at deselect
// - Wrong clock count cancels programming
`timescale 1ns/1ps
module eeprom_device #(
    parameter int AW = eeprom_pkg::ADDR_W,
    parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYC
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    // Serial link
    eeprom_link_if.device link,
    // Status
    output logic program_enabled,
    output logic prog_busy
);
    localparam int DW = eeprom_pkg::DATA_W;
    localparam int OW = eeprom_pkg::OP_W;
    localparam int WORDS = 1 << AW;
    localparam int CW = $clog2(OW + AW + DW + 2);
    localparam int TW = $clog2(PROG_CYCLES);
    localparam int IW = $clog2(DW);
    localparam logic [CW-1:0] CNT_OP = CW'(OW - 1);
    localparam logic [CW-1:0] CNT_EXT = CW'(OW + 1);
    localparam logic [CW-1:0] CNT_LAST_ADDR = CW'(OW + AW - 1);
    localparam logic [CW-1:0] CNT_SHORT = CW'(OW + AW);
    localparam logic [CW-1:0] CNT_FULL = CW'(OW + AW + DW);
    localparam logic [IW-1:0] IDX_LAST = IW'(DW - 1);
    localparam logic [TW-1:0] TMR_LOAD = TW'(PROG_CYCLES - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_READ} dev_fsm_type;

    typedef struct packed {
        dev_fsm_type st;
        logic pe;
        logic busy;
        logic verify;
        logic [TW-1:0] tmr;
        logic [CW-1:0] cnt;
        logic [OW-1:0] op;
        logic [1:0] ext;
        logic [AW+DW-1:0] sh;
        logic [AW-1:0] addr;
        logic [DW-1:0] word;
        logic [IW-1:0] idx;
        logic sclk_p;
        logic sdo;
        logic oe;
        logic wr_en;
        logic wr_all;
        logic [AW-1:0] wr_addr;
        logic [DW-1:0] wr_data;
    } dev_state_type;

    dev_state_type q;
    dev_state_type d;

    logic [DW-1:0] mem [0:WORDS-1];
    logic [2:0] pins_s;
    logic cs_s;
    logic sclk_s;
    logic sdi_s;
    logic rise;
    logic ok_write;
    logic ok_erase;
    logic [AW-1:0] addr_inc;
    logic [AW-1:0] addr_first;
    logic [DW-1:0] rd_first;
    logic [DW-1:0] rd_next;

    link_sync #(.W(3)) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .async_in({link.cs, link.sclk, link.sdi}),
        .sync_out(pins_s)
    );

    assign cs_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s = pins_s[0];
    assign rise = sclk_s && !q.sclk_p;
    assign addr_inc = q.addr + 1'b1;
    assign addr_first = {q.sh[AW-2:0], sdi_s};
    assign rd_first = mem[addr_first];
    assign rd_next = mem[addr_inc];

    // Exact clock count per programming command
    assign ok_write = (q.op == eeprom_pkg::OP_WRITE
        || (q.op == eeprom_pkg::OP_EXT && q.ext == eeprom_pkg::EXT_WRITE_ALL))
        && q.cnt == CNT_FULL;
    assign ok_erase = (q.op == eeprom_pkg::OP_ERASE
        || (q.op == eeprom_pkg::OP_EXT && q.ext == eeprom_pkg::EXT_ERASE_ALL))
        && q.cnt == CNT_SHORT;

    always_comb begin
        d = q;
        d.wr_en = 1'b0;
        d.sclk_p = sclk_s;
        // Program cycle timer runs whatever the select does
        if (q.busy) begin
            if (q.tmr == '0) begin
                d.busy = 1'b0;
            end else begin
                d.tmr = q.tmr - 1'b1;
            end
        end
        if (!cs_s) begin
            d.st = ST_IDLE;
            d.oe = 1'b0;
            if (q.st == ST_RX) begin
                // Command ends here
                if (q.pe && (ok_write || ok_erase)) begin
                    d.busy = 1'b1;
                    d.tmr = TMR_LOAD;
                    d.verify = 1'b1;
                    d.wr_en = 1'b1;
                    d.wr_all = q.op == eeprom_pkg::OP_EXT;
                    d.wr_addr = ok_write ? q.sh[DW +: AW] : q.sh[AW-1:0];
                    d.wr_data = ok_write ? q.sh[DW-1:0] : eeprom_pkg::ERASED_WORD;
                end
                if (q.op == eeprom_pkg::OP_EXT && q.cnt > CNT_EXT) begin
                    if (q.ext == eeprom_pkg::EXT_ENABLE) begin
                        d.pe = 1'b1;
                    end else if (q.ext == eeprom_pkg::EXT_DISABLE) begin
                        d.pe = 1'b0;
                    end
                end
            end
        end else begin
            unique case (q.st)
                ST_IDLE: begin
                    // Status is shown only after a program cycle was started
                    d.oe = q.verify;
                    d.sdo = !q.busy;
                    // Low samples are dummy clocks; busy ignores the pins
                    if (rise && sdi_s && !q.busy) begin
                        d.st = ST_RX;
                        d.cnt = '0;
                        d.verify = 1'b0;
                        d.oe = 1'b0;
                    end
                end
                ST_RX: begin
                    if (rise) begin
                        d.sh = {q.sh[AW+DW-2:0], sdi_s};
                        d.cnt = (q.cnt == '1) ? q.cnt : q.cnt + 1'b1;
                        if (q.cnt == CNT_OP) begin
                            d.op = {q.sh[0], sdi_s};
                        end
                        if (q.cnt == CNT_EXT) begin
                            d.ext = {q.sh[0], sdi_s};
                        end
                        if (q.cnt == CNT_LAST_ADDR && q.op == eeprom_pkg::OP_READ) begin
                            d.st = ST_READ;
                            d.addr = addr_first;
                            d.word = rd_first;
                            d.idx = '0;
                            d.oe = 1'b1;
                            d.sdo = 1'b0;
                        end
                    end
                end
                ST_READ: begin
                    if (rise) begin
                        d.sdo = q.word[DW-1];
                        d.word = {q.word[DW-2:0], 1'b0};
                        d.idx = q.idx + 1'b1;
                        if (q.idx == IDX_LAST) begin
                            d.idx = '0;
                            d.addr = addr_inc;
                            d.word = rd_next;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // Array: all ones after reset, written one cycle after select falls
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < WORDS; i++) begin
                mem[i] <= eeprom_pkg::ERASED_WORD;
            end
        end else if (ce && q.wr_en) begin
            for (int i = 0; i < WORDS; i++) begin
                if (q.wr_all || AW'(i) == q.wr_addr) begin
                    mem[i] <= q.wr_data;
                end
            end
        end
    end

    assign link.sdo_out = q.sdo;
    assign link.sdo_oe = q.oe;
    assign program_enabled = q.pe;
    assign prog_busy = q.busy;
endmodule

// ===== hdl/eeprom_host.sv
/*
 Host end of the three-wire serial word EEPROM link: frames one command,
 makes the serial clock by dividing ref_clk, collects read words and
 polls program status.
 Assumes the data-out line reads high when the device floats it.
*/
`timescale 1ns/1ps
module eeprom_host #(
    parameter int AW = eeprom_pkg::ADDR_W,
    parameter int PAD = eeprom_pkg::LEAD_PAD_SMALL,
    parameter int HALF = eeprom_pkg::SK_HALF_CYC
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    // Command
    input wire logic cmd_valid,
    input wire eeprom_pkg::cmd_type cmd_kind,
    input wire logic [AW-1:0] cmd_addr,
    input wire logic [eeprom_pkg::DATA_W-1:0] cmd_data,
    input wire logic [eeprom_pkg::WORDS_W-1:0] cmd_words,
    output logic cmd_ready,
    // Read data
    output logic rsp_valid,
    output logic [eeprom_pkg::DATA_W-1:0] rsp_data,
    // Serial link
    eeprom_link_if.host link
);
    localparam int DW = eeprom_pkg::DATA_W;
    localparam int OW = eeprom_pkg::OP_W;
    localparam int FW = PAD + 1 + OW + AW + DW;
    localparam int RW = 16;
    localparam int HW = $clog2(HALF + eeprom_pkg::GAP_CYC + eeprom_pkg::POLL_SETTLE_CYC + 1);
    localparam int BW = $clog2(DW);
    localparam logic [HW-1:0] HALF_LAST = HW'(HALF - 1);
    localparam logic [HW-1:0] GAP_LAST = HW'(eeprom_pkg::GAP_CYC - 1);
    localparam logic [HW-1:0] SETTLE_LAST = HW'(eeprom_pkg::POLL_SETTLE_CYC - 1);
    localparam logic [RW-1:0] NB_HEAD = RW'(PAD + 1 + OW + AW);
    localparam logic [BW-1:0] BIT_LAST = BW'(DW - 1);

    typedef enum logic [1:0] {H_IDLE, H_FRAME, H_GAP, H_POLL} host_fsm_type;

    typedef struct packed {
        host_fsm_type st;
        logic cs;
        logic sclk;
        logic sdi;
        logic [HW-1:0] half;
        logic [FW-1:0] sh;
        logic [RW-1:0] nb;
        logic [RW-1:0] rises;
        logic [RW-1:0] total;
        logic rd;
        logic prog;
        logic [DW-1:0] rword;
        logic [BW-1:0] bitc;
        logic cmd_ready;
        logic rsp_valid;
        logic [DW-1:0] rsp_data;
    } host_state_type;

    host_state_type q;
    host_state_type d;

    logic sdo_s;
    logic [OW-1:0] f_op;
    logic [AW-1:0] f_addr;
    logic f_data;
    logic f_prog;
    logic [FW-1:0] frame;
    logic [RW-1:0] f_nb;

    link_sync #(.W(1)) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .async_in(link.sdo_line),
        .sync_out(sdo_s)
    );

    // Opcode and address layout of each command
    always_comb begin
        f_op = eeprom_pkg::OP_EXT;
        f_addr = cmd_addr;
        f_data = 1'b0;
        f_prog = 1'b1;
        unique case (cmd_kind)
            eeprom_pkg::CMD_READ: begin
                f_op = eeprom_pkg::OP_READ;
                f_prog = 1'b0;
            end
            eeprom_pkg::CMD_WRITE: begin
                f_op = eeprom_pkg::OP_WRITE;
                f_data = 1'b1;
            end
            eeprom_pkg::CMD_ERASE: f_op = eeprom_pkg::OP_ERASE;
            eeprom_pkg::CMD_WRITE_ALL: begin
                f_addr = {eeprom_pkg::EXT_WRITE_ALL, cmd_addr[AW-3:0]};
                f_data = 1'b1;
            end
            eeprom_pkg::CMD_ERASE_ALL: f_addr = {eeprom_pkg::EXT_ERASE_ALL, cmd_addr[AW-3:0]};
            eeprom_pkg::CMD_ENABLE: begin
                f_addr = {eeprom_pkg::EXT_ENABLE, cmd_addr[AW-3:0]};
                f_prog = 1'b0;
            end
            eeprom_pkg::CMD_DISABLE: begin
                f_addr = {eeprom_pkg::EXT_DISABLE, cmd_addr[AW-3:0]};
                f_prog = 1'b0;
            end
            default: f_prog = 1'b0;
        endcase
        // Leading zeros above the start bit become dummy clocks
        frame = FW'({1'b1, f_op, f_addr, f_data ? cmd_data : {DW{1'b0}}});
        f_nb = f_data ? NB_HEAD + RW'(DW) : NB_HEAD;
    end

    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        unique case (q.st)
            H_IDLE: begin
                if (q.cmd_ready && cmd_valid) begin
                    d.st = H_FRAME;
                    d.cs = 1'b1;
                    d.sclk = 1'b0;
                    d.sdi = frame[FW-1];
                    d.sh = {frame[FW-2:0], 1'b0};
                    d.half = '0;
                    d.rises = '0;
                    d.nb = f_nb;
                    d.rd = cmd_kind == eeprom_pkg::CMD_READ;
                    d.total = f_nb;
                    if (cmd_kind == eeprom_pkg::CMD_READ) begin
                        d.total = f_nb + RW'(DW * cmd_words);
                    end
                    d.prog = f_prog;
                    d.bitc = '0;
                end
            end
            H_FRAME: begin
                d.half = q.half + 1'b1;
                if (q.half == HALF_LAST) begin
                    d.half = '0;
                    d.sclk = !q.sclk;
                    if (!q.sclk) begin
                        d.rises = q.rises + 1'b1;
                    end else begin
                        d.sdi = q.sh[FW-1];
                        d.sh = {q.sh[FW-2:0], 1'b0};
                        if (q.rd && q.rises > q.nb) begin
                            d.rword = {q.rword[DW-2:0], sdo_s};
                            d.bitc = q.bitc + 1'b1;
                            if (q.bitc == BIT_LAST) begin
                                d.bitc = '0;
                                d.rsp_valid = 1'b1;
                                d.rsp_data = {q.rword[DW-2:0], sdo_s};
                            end
                        end
                        if (q.rises == q.total) begin
                            d.st = H_GAP;
                            d.cs = 1'b0;
                            d.sdi = 1'b0;
                        end
                    end
                end
            end
            H_GAP: begin
                d.half = q.half + 1'b1;
                if (q.half == GAP_LAST) begin
                    d.half = '0;
                    d.st = q.prog ? H_POLL : H_IDLE;
                    d.cs = q.prog;
                end
            end
            H_POLL: begin
                // Input stays low so no start bit is seen
                d.sdi = 1'b0;
                if (q.half != SETTLE_LAST) begin
                    d.half = q.half + 1'b1;
                end else if (sdo_s) begin
                    d.cs = 1'b0;
                    d.prog = 1'b0;
                    d.half = '0;
                    d.st = H_GAP;
                end
            end
        endcase
        d.cmd_ready = d.st == H_IDLE && sdo_s;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign link.cs = q.cs;
    assign link.sclk = q.sclk;
    assign link.sdi = q.sdi;
    assign cmd_ready = q.cmd_ready;
    assign rsp_valid = q.rsp_valid;
    assign rsp_data = q.rsp_data;
endmodule

// ===== tb/eeprom_link_chk.sv
/*
 Concurrent checks on the pins between the host end and the device end.
 Assumes one ref_clk domain and srst synchronous, active high.
*/
`timescale 1ns/1ps
module eeprom_link_chk #(
    parameter int unsigned PROG_CYCLES = 50,
    parameter int GAP = 20
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Link pins
    input wire logic cs,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    logic [7:0] gap_q;
    logic [31:0] low_q;

    // Cycles with select low, and cycles with data out driven low
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gap_q <= 8'hFF;
            low_q <= 32'h0;
        end else begin
            gap_q <= cs ? 8'h00 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
            low_q <= (sdo_oe && !sdo_out) ? low_q + 32'h1 : 32'h0;
        end
    end

    sequence s_open;
        $rose(cs);
    endsequence
    sequence s_pad;
        !sdi [*8];
    endsequence

    property p_open_pad;
        s_open |-> !sclk ##0 s_pad;
    endproperty
    a_open_pad: assert property (p_open_pad)
        else $error("frame opened with clock high or data not low");
    property p_gap;
        s_open |-> gap_q >= GAP - 1;
    endproperty
    a_gap: assert property (p_gap)
        else $error("select low gap too short");
    property p_clk_idle;
        !cs |-> !sclk;
    endproperty
    a_clk_idle: assert property (p_clk_idle)
        else $error("serial clock moves while deselected");
    property p_sdi_stable;
        $rose(sclk) |-> $stable(sdi);
    endproperty
    a_sdi_stable: assert property (p_sdi_stable)
        else $error("data in changed at clock rise");
    property p_float;
        !cs [*6] |-> !sdo_oe;
    endproperty
    a_float: assert property (p_float)
        else $error("data out driven while deselected");
    property p_oe_cs;
        $rose(sdo_oe) |-> cs;
    endproperty
    a_oe_cs: assert property (p_oe_cs)
        else $error("data out enabled without select");
    property p_dummy;
        $rose(sdo_oe) && sclk |-> !sdo_out;
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("read dummy bit not low");
    property p_busy_end;
        low_q <= PROG_CYCLES + 64;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy status lasts too long");
endmodule

// ===== tb/serial_eeprom_command_port_tb.sv
/*
 Testbench joining host and device ends over the link interface.
 Assumes a 100 MHz ref_clk and a shortened program cycle.
*/
`timescale 1ns/1ps
module serial_eeprom_command_port_tb;
    localparam int unsigned PROG = 50;
    localparam int LIMIT = 20000;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    eeprom_pkg::cmd_type cmd_kind = eeprom_pkg::CMD_READ;
    logic [5:0] cmd_addr = 6'h00;
    logic [15:0] cmd_data = 16'h0000;
    logic [7:0] cmd_words = 8'h00;
    logic cmd_ready;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic program_enabled;
    logic prog_busy;
    logic [15:0] mem [64];
    logic en = 1'b0;
    logic ce = 1'b1;
    int fail_count = 0;
    int checks = 0;

    always #5 ref_clk = ~ref_clk;

    eeprom_link_if eeprom_link_if_inst();
    eeprom_host #(.AW(6), .PAD(7), .HALF(8)) eeprom_host_inst (
        .ref_clk(ref_clk), .srst(srst), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_words(cmd_words), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .link(eeprom_link_if_inst.host)
    );
    eeprom_device #(.AW(6), .PROG_CYCLES(PROG)) eeprom_device_inst (
        .ref_clk(ref_clk), .srst(srst), .ce(ce), .link(eeprom_link_if_inst.device),
        .program_enabled(program_enabled), .prog_busy(prog_busy)
    );
    eeprom_link_chk #(.PROG_CYCLES(PROG), .GAP(eeprom_pkg::GAP_CYC)) eeprom_link_chk_inst (
        .ref_clk(ref_clk), .srst(srst), .cs(eeprom_link_if_inst.cs),
        .sclk(eeprom_link_if_inst.sclk), .sdi(eeprom_link_if_inst.sdi),
        .sdo_out(eeprom_link_if_inst.sdo_out), .sdo_oe(eeprom_link_if_inst.sdo_oe)
    );

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic timed_out();
        fail_count++;
        $display("Wait limit reached at %0t", $time);
        end_of_test();
    endtask

    task automatic check(logic [15:0] got, logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready();
        int i;
        for (i = 0; i < LIMIT && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
        if (i == LIMIT) timed_out();
    endtask

    task automatic send(eeprom_pkg::cmd_type k, logic [5:0] a, logic [15:0] d, logic [7:0] n);
        wait_ready();
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_words <= n;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        @(negedge ref_clk);
    endtask

    // Sends a non-read command and updates the expected array
    task automatic prog(eeprom_pkg::cmd_type k, logic [5:0] a, logic [15:0] d);
        logic all;
        logic one;
        int j;
        send(k, a, d, 8'h00);
        if (k == eeprom_pkg::CMD_ENABLE) en = 1'b1;
        if (k == eeprom_pkg::CMD_DISABLE) en = 1'b0;
        all = (k == eeprom_pkg::CMD_WRITE_ALL) || (k == eeprom_pkg::CMD_ERASE_ALL);
        one = (k == eeprom_pkg::CMD_WRITE) || (k == eeprom_pkg::CMD_ERASE);
        for (int i = 0; i < 64; i++) begin
            if (en && (all || (one && i == a))) begin
                mem[i] = (k == eeprom_pkg::CMD_WRITE || k == eeprom_pkg::CMD_WRITE_ALL) ?
                    d : eeprom_pkg::ERASED_WORD;
            end
        end
        // An accepted programming command must start a program cycle
        if (en && (all || one)) begin
            for (j = 0; j < LIMIT && prog_busy !== 1'b1; j++) @(negedge ref_clk);
            if (j == LIMIT) timed_out();
            check({15'h0000, prog_busy}, 16'h0001);
        end
    endtask

    // Reads n words from a and compares each with the expected array
    task automatic rd(logic [5:0] a, int n, int hold = 0);
        int j;
        send(eeprom_pkg::CMD_READ, a, 16'h0000, n[7:0]);
        // Optional freeze of both ends just after the frame opens
        if (hold > 0) begin
            @(posedge ref_clk);
            ce <= 1'b0;
            repeat (hold) @(posedge ref_clk);
            @(negedge ref_clk);
            check({14'h0000, eeprom_link_if_inst.cs, eeprom_link_if_inst.sclk}, 16'h0002);
            @(posedge ref_clk);
            ce <= 1'b1;
        end
        for (int i = 0; i < n; i++) begin
            for (j = 0; j < LIMIT && rsp_valid !== 1'b1; j++) @(negedge ref_clk);
            if (j == LIMIT) timed_out();
            check(rsp_data, mem[(a + i) % 64]);
            @(negedge ref_clk);
        end
    endtask

    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 16'hFFFF;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        rd(6'h00, 2);
        $display("Test delivered state done");
        prog(eeprom_pkg::CMD_WRITE, 6'h03, 16'h1234);
        rd(6'h03, 1);
        $display("Test write lockout done");
        prog(eeprom_pkg::CMD_ENABLE, 6'h00, 16'h0000);
        wait_ready();
        check({15'h0000, program_enabled}, 16'h0001);
        prog(eeprom_pkg::CMD_WRITE, 6'h3F, 16'hA5A5);
        prog(eeprom_pkg::CMD_WRITE, 6'h00, 16'h5A5A);
        wait_ready();
        check({15'h0000, prog_busy}, 16'h0000);
        rd(6'h3F, 3);
        prog(eeprom_pkg::CMD_ERASE, 6'h3F, 16'h0000);
        rd(6'h3E, 3);
        $display("Test word program and wrap done");
        prog(eeprom_pkg::CMD_WRITE_ALL, 6'h00, 16'h0F0F);
        rd(6'h0A, 2);
        prog(eeprom_pkg::CMD_ERASE_ALL, 6'h00, 16'h0000);
        rd(6'h14, 2, 200);
        $display("Test chip program done");
        prog(eeprom_pkg::CMD_DISABLE, 6'h00, 16'h0000);
        wait_ready();
        check({15'h0000, program_enabled}, 16'h0000);
        prog(eeprom_pkg::CMD_WRITE, 6'h05, 16'hBEEF);
        rd(6'h05, 1);
        $display("Test program disable done");
        end_of_test();
    end
endmodule
